// File: bench/flash_status_monitor.sv
// Concurrent checks on the ports of the flash status block.
`timescale 1ns/1ps
module flash_status_monitor
    import flash_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [flash_status_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic command_complete,
    input wire logic sequence_violation,
    input wire logic illegal_command,
    input wire logic protected_target,
    input wire logic ecc_single_fault,
    input wire logic ecc_double_fault,
    input wire logic read_collision,
    input wire logic command_launch,
    input wire logic sequence_start_allowed,
    input wire logic command_done_irq,
    input wire logic single_fault_irq,
    input wire logic double_fault_irq
);
    logic wr;
    assign wr = psel && penable && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    launch_cause_a: assert property (command_launch |-> $past(wr && paddr == {IDX_COMMAND_STATUS, 2'b00}
        && pwdata[7]) && $past(sequence_start_allowed)) else $error("launch without cause");
    prot_block_a: assert property (protected_target |=> !sequence_start_allowed)
        else $error("start allowed after violation");
    prot_clear_a: assert property ($rose(sequence_start_allowed) |-> $past(wr && pwdata[4]
        && paddr == {IDX_COMMAND_STATUS, 2'b00})) else $error("violation cleared without write");
    dbl_irq_a: assert property ($rose(double_fault_irq) |-> $past(ecc_double_fault || read_collision
        || (wr && paddr == {IDX_ERROR_IRQ_ENABLE, 2'b00}))) else $error("double irq without cause");
    sgl_irq_a: assert property ($rose(single_fault_irq) |-> $past(ecc_single_fault || read_collision
        || (wr && paddr == {IDX_ERROR_IRQ_ENABLE, 2'b00}))) else $error("single irq without cause");
    dbl_clear_a: assert property (wr && paddr == {IDX_FAULT_STATUS, 2'b00} && pwdata[1] && !ecc_double_fault
        && !read_collision |=> !double_fault_irq) else $error("double flag not cleared");
    sgl_clear_a: assert property (wr && paddr == {IDX_FAULT_STATUS, 2'b00} && pwdata[0] && !ecc_single_fault
        && !read_collision |=> !single_fault_irq) else $error("single flag not cleared");
    cmd_irq_a: assert property ($rose(command_done_irq) |-> $past(command_complete || sequence_violation
        || illegal_command || protected_target || (wr && paddr == {IDX_FLASH_CONFIG, 2'b00})))
        else $error("done irq without cause");
    ready_high_a: assert property (pready) else $error("pready low");
    err_phase_a: assert property (!penable |-> !pslverr) else $error("pslverr outside access");
    // ------------------------------------------------------------
    // Covers.
    // ------------------------------------------------------------
    launch_c: cover property (command_launch);
    collide_c: cover property (read_collision);
    slverr_c: cover property (pslverr);
    prot_c: cover property (protected_target);
endmodule // flash_status_monitor

bind flash_status_error_flags flash_status_monitor i_flash_status_monitor (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .command_complete(command_complete), .sequence_violation(sequence_violation),
    .illegal_command(illegal_command), .protected_target(protected_target),
    .ecc_single_fault(ecc_single_fault), .ecc_double_fault(ecc_double_fault),
    .read_collision(read_collision), .command_launch(command_launch),
    .sequence_start_allowed(sequence_start_allowed), .command_done_irq(command_done_irq),
    .single_fault_irq(single_fault_irq), .double_fault_irq(double_fault_irq));

// File: bench/testbench.sv
// Self-checking testbench of the flash status block.
`timescale 1ns/1ps
module testbench;
    import flash_status_pkg::*;
    localparam logic [13:0] A_CFG = {IDX_FLASH_CONFIG, 2'b00};
    localparam logic [13:0] A_EN = {IDX_ERROR_IRQ_ENABLE, 2'b00};
    localparam logic [13:0] A_ST = {IDX_COMMAND_STATUS, 2'b00};
    localparam logic [13:0] A_FS = {IDX_FAULT_STATUS, 2'b00};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, command_launch, sequence_start_allowed;
    logic command_done_irq, single_fault_irq, double_fault_irq;
    logic [7:0] ev = 8'h00;
    logic [1:0] cmd_err = 2'h0, rst_err = 2'h0;
    logic rst_dbl = 1'b0;
    int n_errors = 0, comparisons = 0;
    always #5 pclk = ~pclk;
    flash_status_error_flags i_flash_status_error_flags (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .command_complete(ev[0]), .command_completion_error(cmd_err),
        .sequence_violation(ev[1]), .illegal_command(ev[2]), .protected_target(ev[3]),
        .reset_sequence_done(ev[7]), .reset_sequence_error(rst_err), .reset_sequence_double_fault(rst_dbl),
        .ecc_single_fault(ev[4]), .ecc_double_fault(ev[5]), .read_collision(ev[6]),
        .command_launch(command_launch), .sequence_start_allowed(sequence_start_allowed),
        .command_done_irq(command_done_irq), .single_fault_irq(single_fault_irq),
        .double_fault_irq(double_fault_irq));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic [13:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            check("pready", 1, pready);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, {24'h000000, d}, r, e);
    endtask
    task automatic rd(input logic [13:0] a, input logic [7:0] exp, input logic [7:0] m);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0000_0000, r, e);
        check("register", {24'h000000, exp & m}, r & {24'h000000, m});
    endtask
    task automatic pulse(input int i);
        @(posedge pclk);
        ev <= 8'h01 << i;
        @(posedge pclk);
        ev <= 8'h00;
        #1;
    endtask
    task automatic t_reset_values();
        rd(A_CFG, 8'h00, 8'hFF);
        rd(A_EN, 8'h00, 8'hFF);
        rd(A_ST, 8'h80, 8'hFF);
        rd(A_FS, 8'h00, 8'hFF);
        check("allowed", 1, sequence_start_allowed);
    endtask
    task automatic t_access_kinds();
        logic [31:0] r;
        logic e;
        wr(A_EN, 8'hFF);
        rd(A_EN, 8'h03, 8'hFF);
        wr(A_CFG, 8'hFF);
        rd(A_CFG, 8'h90, 8'hFF);
        wr(A_CFG, 8'h00);
        wr(A_EN, 8'h00);
        apb(14'h0420, 1'b0, 32'h0000_0000, r, e);
        check("pslverr", 1, e);
        wr(A_ST, 8'h0F);
        #1 check("launch", 0, command_launch);
        rd(A_ST, 8'h80, 8'hFF);
    endtask
    task automatic t_launch();
        wr(A_CFG, 8'h80);
        #1 check("done irq", 1, command_done_irq);
        wr(A_ST, 8'h80);
        #1 check("launch", 1, command_launch);
        check("done irq", 0, command_done_irq);
        rd(A_ST, 8'h08, 8'hFF);
        cmd_err <= 2'h1;
        wr(A_ST, 8'h80);
        #1 check("launch", 0, command_launch);
        pulse(0);
        check("done irq", 1, command_done_irq);
        rd(A_ST, 8'h81, 8'hFF);
        wr(A_CFG, 8'h00);
        #1 check("done irq", 0, command_done_irq);
    endtask
    task automatic t_errors();
        pulse(1);
        wr(A_ST, 8'h80);
        #1 check("launch", 0, command_launch);
        rd(A_ST, 8'hA1, 8'hFF);
        wr(A_ST, 8'h00);
        rd(A_ST, 8'hA1, 8'hFF);
        wr(A_ST, 8'h20);
        pulse(2);
        rd(A_ST, 8'hA1, 8'hFF);
        wr(A_ST, 8'h20);
        pulse(3);
        check("allowed", 0, sequence_start_allowed);
        wr(A_ST, 8'h80);
        #1 check("launch", 0, command_launch);
        wr(A_ST, 8'h00);
        rd(A_ST, 8'h91, 8'hFF);
        wr(A_ST, 8'h10);
        #1 check("allowed", 1, sequence_start_allowed);
        wr(A_ST, 8'h80);
        #1 check("launch", 1, command_launch);
        pulse(1);
        rd(A_ST, 8'hA0, 8'hFC);
        wr(A_ST, 8'h20);
    endtask
    task automatic t_faults();
        wr(A_FS, 8'h03);
        rd(A_FS, 8'h00, 8'hFF);
        wr(A_EN, 8'h03);
        pulse(5);
        check("dbl irq", 1, double_fault_irq);
        check("sgl irq", 0, single_fault_irq);
        wr(A_FS, 8'h01);
        rd(A_FS, 8'h02, 8'hFF);
        wr(A_FS, 8'h02);
        #1 check("dbl irq", 0, double_fault_irq);
        pulse(4);
        rd(A_FS, 8'h01, 8'hFF);
        check("sgl irq", 1, single_fault_irq);
        wr(A_FS, 8'h00);
        wr(A_EN, 8'h01);
        wr(A_FS, 8'h01);
        pulse(6);
        rd(A_FS, 8'h03, 8'hFF);
        check("dbl irq", 0, double_fault_irq);
        check("sgl irq", 1, single_fault_irq);
        wr(A_FS, 8'h03);
        wr(A_CFG, 8'h10);
        pulse(4);
        rd(A_FS, 8'h00, 8'hFF);
        check("sgl irq", 0, single_fault_irq);
    endtask
    task automatic t_reset_sequence();
        rst_err <= 2'h2;
        pulse(7);
        rd(A_ST, 8'h82, 8'hFF);
        rst_dbl <= 1'b1;
        pulse(7);
        rd(A_ST, 8'h83, 8'hFF);
    endtask
    task automatic final_report();
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_access_kinds();
        t_launch();
        t_errors();
        t_faults();
        t_reset_sequence();
        final_report();
    end
    initial begin
        #200000;
        n_errors++;
        $display("unexpected watchdog: expected finish seen timeout");
        final_report();
    end
endmodule // testbench

// File: shared/flash_status_pkg.sv
// Package with register indices, field positions and reset values of the flash status block.
package flash_status_pkg;

    // ------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_FLASH_CONFIG = 12'h104;
    localparam logic [11:0] IDX_ERROR_IRQ_ENABLE = 12'h105;
    localparam logic [11:0] IDX_COMMAND_STATUS = 12'h106;
    localparam logic [11:0] IDX_FAULT_STATUS = 12'h107;
    localparam int unsigned BYTE_LANE_BITS = 2;
    localparam int unsigned ADDR_WIDTH = 14;

    // ------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------
    localparam int unsigned POS_COMMAND_DONE_IRQ_ENABLE = 7;
    localparam int unsigned POS_IGNORE_SINGLE_FAULT = 4;
    localparam int unsigned POS_DOUBLE_FAULT_IRQ_ENABLE = 1;
    localparam int unsigned POS_SINGLE_FAULT_IRQ_ENABLE = 0;
    localparam int unsigned POS_COMMAND_DONE = 7;
    localparam int unsigned POS_ACCESS_ERROR = 5;
    localparam int unsigned POS_PROTECTION_VIOLATION = 4;
    localparam int unsigned POS_CONTROLLER_BUSY = 3;
    localparam int unsigned POS_COMPLETION_LSB = 0;
    localparam int unsigned POS_DOUBLE_FAULT = 1;
    localparam int unsigned POS_SINGLE_FAULT = 0;

    // ------------------------------------------------------------
    // Reset values and write masks.
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_FLASH_CONFIG = 8'h00;
    localparam logic [7:0] RESET_ERROR_IRQ_ENABLE = 8'h00;
    localparam logic RESET_COMMAND_DONE = 1'b1;
    localparam logic [1:0] RESET_COMPLETION = 2'h0;
    localparam logic [7:0] MASK_FLASH_CONFIG = 8'h90;
    localparam logic [7:0] MASK_ERROR_IRQ_ENABLE = 8'h03;

endpackage

// File: shared/reg_access_if.sv
// Interface carrying decoded register writes from the bus port to the register logic.
`timescale 1ns/1ps
interface reg_access_if;
    logic wr_en;
    logic [11:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic hit;

    modport port (output wr_en, output idx, output wdata, input rdata, input hit);
    modport regs (input wr_en, input idx, input wdata, output rdata, output hit);
    modport watch (input wr_en, input idx, input wdata);
endinterface

// File: verilog/apb_reg_port.sv
// APB slave that turns bus transfers into register reads and writes.
`timescale 1ns/1ps
module apb_reg_port
    import flash_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [flash_status_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    reg_access_if.port bus
);
    typedef struct packed {
        logic [7:0] rdata;
    } port_state_t;

    port_state_t state;
    port_state_t next_state;
    logic aligned;

    // ------------------------------------------------------------
    // Decode and handshake.
    // ------------------------------------------------------------
    // Read data is captured in the setup cycle so that the answer comes from a flip-flop.
    assign aligned = (paddr[BYTE_LANE_BITS-1:0] == 2'h0);
    assign bus.idx = paddr[ADDR_WIDTH-1:BYTE_LANE_BITS];
    assign bus.wdata = pwdata[7:0];
    assign bus.wr_en = psel & penable & pwrite & aligned & bus.hit;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(aligned & bus.hit);
    assign prdata = {24'h000000, state.rdata};

    always_comb begin
        next_state = state;
        if (psel && !penable) begin
            next_state.rdata = (aligned && !pwrite) ? bus.rdata : 8'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule // apb_reg_port

// File: verilog/fault_flag_bank.sv
// Write-one-to-clear single and double fault flags of the fault status register.
`timescale 1ns/1ps
module fault_flag_bank
    import flash_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ignore_single_fault,
    input wire logic ecc_single_fault,
    input wire logic ecc_double_fault,
    input wire logic read_collision,
    reg_access_if.watch bus,
    output logic single_fault_flag,
    output logic double_fault_flag
);
    typedef struct packed {
        logic single_fault;
        logic double_fault;
    } fault_state_t;

    fault_state_t state;
    fault_state_t next_state;
    logic clear_write;
    logic set_single;
    logic set_double;

    // A genuine fault is either single or double; a double fault overrides a single one.
    // A collision sets both flags. Sets win over a clear in the same cycle.
    assign clear_write = bus.wr_en && (bus.idx == IDX_FAULT_STATUS);
    assign set_double = ecc_double_fault | read_collision;
    assign set_single = (ecc_single_fault & ~ecc_double_fault & ~ignore_single_fault) | read_collision;

    always_comb begin
        next_state = state;
        if (clear_write && bus.wdata[POS_SINGLE_FAULT]) begin
            next_state.single_fault = 1'b0;
        end
        if (clear_write && bus.wdata[POS_DOUBLE_FAULT]) begin
            next_state.double_fault = 1'b0;
        end
        if (set_single) begin
            next_state.single_fault = 1'b1;
        end
        if (set_double) begin
            next_state.double_fault = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign single_fault_flag = state.single_fault;
    assign double_fault_flag = state.double_fault;
endmodule // fault_flag_bank

// File: verilog/flash_status_error_flags.sv
// Status, error flag and interrupt request logic of the flash controller.
// What this block does
// - Double-fault flag with its enable set requests an interrupt; cleared enable blocks it.
// - Single-fault flag with its enable set requests an interrupt; cleared enable blocks it.
// - Both enable bits of the error interrupt enable register read back and write.
// - Command-done reads 1 when idle; writing 1 launches and clears until completion.
// - Access error sets on sequence violation or illegal command; write 1 clears.
// - With access error set, command-done write neither clears nor launches.
// - Protection violation sets on protected program or erase; write 1 clears.
// - With protection violation set, no launch and no new sequence start.
// - Busy flag reads 1 while a command runs, 0 when idle.
// - Bit 2 of the command status register always reads 0.
// - Completion status sets bits on errors in a command or the reset sequence.
// - Only done, access error and protection bits take writes; other bits fixed.
// - Double-fault flag sets on uncorrectable fault or busy-block read; write 1 clears.
// - Single-fault flag sets on corrected fault or busy-block read; write 1 clears.
// - A genuine fault sets single or double flag, never both.
// - A read colliding with a running command sets both fault flags.
// - Status after reset may differ when the reset sequence finds a double fault.
// - Fault flags are readable; writes can only clear them.
// - Ignore-single-fault set stops single-fault reporting of corrected faults and its interrupt; a colliding read still sets the flag.
// - Command-done flag with its enable set requests an interrupt.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module flash_status_error_flags
    import flash_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [flash_status_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic command_complete,
    input wire logic [1:0] command_completion_error,
    input wire logic sequence_violation,
    input wire logic illegal_command,
    input wire logic protected_target,
    input wire logic reset_sequence_done,
    input wire logic [1:0] reset_sequence_error,
    input wire logic reset_sequence_double_fault,
    input wire logic ecc_single_fault,
    input wire logic ecc_double_fault,
    input wire logic read_collision,
    output logic command_launch,
    output logic sequence_start_allowed,
    output logic command_done_irq,
    output logic single_fault_irq,
    output logic double_fault_irq
);

    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_IDLE = 2'b01,
        CMD_RUNNING = 2'b10
    } cmd_phase_t;

    typedef struct packed {
        logic [7:0] flash_config;
        logic [7:0] error_irq_enable;
        cmd_phase_t phase;
        logic command_done;
        logic access_error;
        logic protection_violation;
        logic [1:0] completion_status;
        logic launch;
    } status_state_t;

    status_state_t state;
    status_state_t next_state;

    reg_access_if bus ();

    logic single_fault_flag;
    logic double_fault_flag;
    logic status_write;
    logic config_write;
    logic enable_write;
    logic launch_request;
    logic launch_allowed;
    logic access_error_event;
    logic protection_event;
    logic command_violation;
    logic [7:0] command_status_reg;
    logic [7:0] fault_status_reg;
    logic [7:0] error_interrupt_enable_reg;
    logic [7:0] flash_config_reg;
    logic controller_busy_flag;

    // ------------------------------------------------------------
    // Bus port and fault flags.
    // ------------------------------------------------------------
    apb_reg_port u_port (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .bus(bus.port)
    );

    fault_flag_bank u_faults (
        .pclk(pclk),
        .presetn(presetn),
        .ignore_single_fault(state.flash_config[POS_IGNORE_SINGLE_FAULT]),
        .ecc_single_fault(ecc_single_fault),
        .ecc_double_fault(ecc_double_fault),
        .read_collision(read_collision),
        .bus(bus.watch),
        .single_fault_flag(single_fault_flag),
        .double_fault_flag(double_fault_flag)
    );

    // ------------------------------------------------------------
    // Write decode.
    // ------------------------------------------------------------
    assign status_write = bus.wr_en && (bus.idx == IDX_COMMAND_STATUS);
    assign config_write = bus.wr_en && (bus.idx == IDX_FLASH_CONFIG);
    assign enable_write = bus.wr_en && (bus.idx == IDX_ERROR_IRQ_ENABLE);

    // A launch needs an idle controller and both error flags clear as they stand before the write.
    assign launch_request = status_write && bus.wdata[POS_COMMAND_DONE];
    assign launch_allowed = state.command_done & ~state.access_error & ~state.protection_violation;

    // A new sequence may only begin while no protection violation is pending.
    assign sequence_start_allowed = ~state.protection_violation;

    assign access_error_event = sequence_violation | illegal_command;
    assign protection_event = protected_target;
    assign command_violation = (access_error_event | protection_event) && (state.phase == CMD_RUNNING);

    // ------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.launch = 1'b0;

        if (config_write) begin
            next_state.flash_config = bus.wdata & MASK_FLASH_CONFIG;
        end

        if (enable_write) begin
            next_state.error_irq_enable = bus.wdata & MASK_ERROR_IRQ_ENABLE;
        end

        // Write-one-to-clear of the error flags; a zero leaves them alone.
        if (status_write && bus.wdata[POS_ACCESS_ERROR]) begin
            next_state.access_error = 1'b0;
        end
        if (status_write && bus.wdata[POS_PROTECTION_VIOLATION]) begin
            next_state.protection_violation = 1'b0;
        end

        // Hardware events win over a clear in the same cycle.
        if (access_error_event) begin
            next_state.access_error = 1'b1;
        end
        if (protection_event) begin
            next_state.protection_violation = 1'b1;
        end

        case (state.phase)
            CMD_IDLE: begin
                if (launch_request && launch_allowed) begin
                    next_state.command_done = 1'b0;
                    next_state.completion_status = RESET_COMPLETION;
                    next_state.launch = 1'b1;
                    next_state.phase = CMD_RUNNING;
                end
            end
            CMD_RUNNING: begin
                if (command_complete || command_violation) begin
                    next_state.command_done = 1'b1;
                    next_state.phase = CMD_IDLE;
                end
                if (command_complete) begin
                    next_state.completion_status = command_completion_error;
                end
            end
            default: begin
                next_state.phase = CMD_IDLE;
                next_state.command_done = 1'b1;
            end
        endcase

        // The reset sequence reports its own errors; a double fault there forces both bits.
        if (reset_sequence_done) begin
            next_state.completion_status = reset_sequence_error;
            if (reset_sequence_double_fault) begin
                next_state.completion_status = 2'h3;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.flash_config <= RESET_FLASH_CONFIG;
            state.error_irq_enable <= RESET_ERROR_IRQ_ENABLE;
            state.phase <= CMD_IDLE;
            state.command_done <= RESET_COMMAND_DONE;
            state.access_error <= 1'b0;
            state.protection_violation <= 1'b0;
            state.completion_status <= RESET_COMPLETION;
            state.launch <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Read views.
    // ------------------------------------------------------------
    assign controller_busy_flag = ~state.command_done;

    always_comb begin
        command_status_reg = 8'h00;
        command_status_reg[POS_COMMAND_DONE] = state.command_done;
        command_status_reg[POS_ACCESS_ERROR] = state.access_error;
        command_status_reg[POS_PROTECTION_VIOLATION] = state.protection_violation;
        command_status_reg[POS_CONTROLLER_BUSY] = controller_busy_flag;
        command_status_reg[POS_COMPLETION_LSB +: 2] = state.completion_status;
    end

    always_comb begin
        fault_status_reg = 8'h00;
        fault_status_reg[POS_SINGLE_FAULT] = single_fault_flag;
        fault_status_reg[POS_DOUBLE_FAULT] = double_fault_flag;
    end

    assign error_interrupt_enable_reg = state.error_irq_enable;
    assign flash_config_reg = state.flash_config;

    always_comb begin
        bus.hit = 1'b1;
        case (bus.idx)
            IDX_FLASH_CONFIG: bus.rdata = flash_config_reg;
            IDX_ERROR_IRQ_ENABLE: bus.rdata = error_interrupt_enable_reg;
            IDX_COMMAND_STATUS: bus.rdata = command_status_reg;
            IDX_FAULT_STATUS: bus.rdata = fault_status_reg;
            default: begin
                bus.rdata = 8'h00;
                bus.hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------
    assign command_launch = state.launch;

    // Requests are levels that stay up until the flag or its enable is cleared.
    assign command_done_irq = state.command_done & state.flash_config[POS_COMMAND_DONE_IRQ_ENABLE];
    assign single_fault_irq = single_fault_flag & state.error_irq_enable[POS_SINGLE_FAULT_IRQ_ENABLE];
    assign double_fault_irq = double_fault_flag & state.error_irq_enable[POS_DOUBLE_FAULT_IRQ_ENABLE];

endmodule // flash_status_error_flags
